// ==== igf_glitch_filter.sv ====
// isolated i/o glitch filter with relay output latch, axi4-lite slave
// assumes in_pins come from the isolation stage asynchronously to aclk
`default_nettype none

module igf_glitch_filter #(
    parameter int N_IN = 24,
    parameter int N_OUT = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_IN-1:0] in_pins,
    output logic [N_OUT-1:0] relay_ctrl_n,
    output logic [N_IN-1:0] in_level
);

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [N_OUT-1:0] out_data_reg;
    logic [N_IN-1:0] filt_en_reg;
    logic [igf_pkg::INTERVAL_W-1:0] interval_reg;
    logic [N_IN-1:0] change_reg;

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic [31:0] wmask;
    logic wr_hit;

    // address and data are taken in either order, one write in flight
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
                    {8{wstrb_reg[0]}}};
    assign wr_hit = (awaddr_reg == igf_pkg::ADDR_OUT_DATA)
        || (awaddr_reg == igf_pkg::ADDR_FILT_EN)
        || (awaddr_reg == igf_pkg::ADDR_FILT_INTERVAL)
        || (awaddr_reg == igf_pkg::ADDR_CHANGE_STATUS);

    // capture address and data as each arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // write response; unmapped offsets answer slverr and store nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= igf_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? igf_pkg::RESP_OKAY : igf_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    // relays open at reset; stored value drives the active-low pins as is
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_data_reg <= {N_OUT{1'b1}};
        end else if (wr_fire && awaddr_reg == igf_pkg::ADDR_OUT_DATA) begin
            out_data_reg <= (out_data_reg & ~wmask[N_OUT-1:0])
                | (wdata_reg[N_OUT-1:0] & wmask[N_OUT-1:0]);
        end
    end

    assign relay_ctrl_n = out_data_reg;

    // per-line filter select, bypass on every line at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_en_reg <= '0;
        end else if (wr_fire && awaddr_reg == igf_pkg::ADDR_FILT_EN) begin
            filt_en_reg <= (filt_en_reg & ~wmask[N_IN-1:0])
                | (wdata_reg[N_IN-1:0] & wmask[N_IN-1:0]);
        end
    end

    // one interval in microseconds for all lines; range is up to software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interval_reg <= igf_pkg::INTERVAL_RST;
        end else if (wr_fire && awaddr_reg == igf_pkg::ADDR_FILT_INTERVAL) begin
            interval_reg <= (interval_reg & ~wmask[igf_pkg::INTERVAL_W-1:0])
                | (wdata_reg[igf_pkg::INTERVAL_W-1:0]
                & wmask[igf_pkg::INTERVAL_W-1:0]);
        end
    end

    // ****************************************************************
    // input synchroniser and sample clock
    // ****************************************************************
    logic [N_IN-1:0] sync1_reg;
    logic [N_IN-1:0] sync2_reg;
    logic [N_IN-1:0] sync3_reg;
    logic [N_IN-1:0] clean_reg;
    logic [N_IN-1:0] samp_reg;
    logic [4:0] samp_cnt_reg;
    logic sample_en;

    // three flops; a level counts once the second and third agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            clean_reg <= '0;
        end else begin
            sync1_reg <= in_pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            clean_reg <= (sync2_reg & sync3_reg)
                | (clean_reg & (sync2_reg ^ sync3_reg));
        end
    end

    // 100 ns sample tick as a one-cycle enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_cnt_reg <= 5'h00;
        end else if (sample_en) begin
            samp_cnt_reg <= 5'h00;
        end else begin
            samp_cnt_reg <= samp_cnt_reg + 5'h01;
        end
    end

    assign sample_en = (samp_cnt_reg == 5'(igf_pkg::SAMPLE_CYC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_reg <= '0;
        end else if (sample_en) begin
            samp_reg <= clean_reg;
        end
    end

    // ****************************************************************
    // filter clock divider
    // ****************************************************************
    logic [igf_pkg::HALF_W-1:0] half_ticks;
    logic [igf_pkg::HALF_W-1:0] filt_cnt_reg;
    logic filt_tick;

    // sample ticks per half interval; a zero interval is held to one tick
    always_comb begin
        half_ticks = igf_pkg::HALF_W'(({4'h0, interval_reg}
            * igf_pkg::HALF_W'(igf_pkg::SAMPLES_PER_US)) >> 1);
        if (half_ticks == '0) begin
            half_ticks = igf_pkg::HALF_W'(1);
        end
    end

    // counts sample ticks; a shortened interval takes effect at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_cnt_reg <= '0;
        end else if (sample_en) begin
            if (filt_cnt_reg >= half_ticks - igf_pkg::HALF_W'(1)) begin
                filt_cnt_reg <= '0;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + igf_pkg::HALF_W'(1);
            end
        end
    end

    assign filt_tick = sample_en && (filt_cnt_reg >= half_ticks - igf_pkg::HALF_W'(1));

    // ****************************************************************
    // per-line filter, path select and change detection
    // ****************************************************************
    logic [N_IN-1:0] edge_lvl_reg;
    logic [N_IN-1:0] steady_reg;
    logic [N_IN-1:0] filt_q_reg;
    logic [N_IN-1:0] prev_sel_reg;
    logic [N_IN-1:0] sel_lvl;

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_line
            // level seen at the last filter tick and whether every sample
            // since then matched it; one flag serves both directions
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    edge_lvl_reg[gi] <= 1'b0;
                    steady_reg[gi] <= 1'b0;
                    filt_q_reg[gi] <= 1'b0;
                end else if (filt_tick) begin
                    if (steady_reg[gi] && samp_reg[gi] == edge_lvl_reg[gi]) begin
                        filt_q_reg[gi] <= samp_reg[gi];
                    end
                    edge_lvl_reg[gi] <= samp_reg[gi];
                    steady_reg[gi] <= 1'b1;
                end else if (samp_reg[gi] != edge_lvl_reg[gi]) begin
                    steady_reg[gi] <= 1'b0;
                end
            end
            assign sel_lvl[gi] = filt_en_reg[gi] ? filt_q_reg[gi] : clean_reg[gi];
        end
    endgenerate

    // sticky change flags watch the selected path; set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_sel_reg <= '0;
            change_reg <= '0;
        end else begin
            prev_sel_reg <= sel_lvl;
            if (wr_fire && awaddr_reg == igf_pkg::ADDR_CHANGE_STATUS) begin
                change_reg <= (change_reg & ~(wdata_reg[N_IN-1:0]
                    & wmask[N_IN-1:0])) | (sel_lvl ^ prev_sel_reg);
            end else begin
                change_reg <= change_reg | (sel_lvl ^ prev_sel_reg);
            end
        end
    end

    // registered copy of the selected levels for the user side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_level <= '0;
        end else begin
            in_level <= sel_lvl;
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            igf_pkg::ADDR_OUT_DATA: rd_word[N_OUT-1:0] = out_data_reg;
            igf_pkg::ADDR_IN_DATA: rd_word[N_IN-1:0] = sel_lvl;
            igf_pkg::ADDR_FILT_EN: rd_word[N_IN-1:0] = filt_en_reg;
            igf_pkg::ADDR_FILT_INTERVAL: rd_word[igf_pkg::INTERVAL_W-1:0] = interval_reg;
            igf_pkg::ADDR_CHANGE_STATUS: rd_word[N_IN-1:0] = change_reg;
            igf_pkg::ADDR_RAW_IN: rd_word[N_IN-1:0] = clean_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= igf_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? igf_pkg::RESP_OKAY : igf_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_relay_open_rst: assert property (@(posedge aclk)
        !aresetn |=> relay_ctrl_n == {N_OUT{1'b1}})
        else $error("relays not open after reset");

    a_relay_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && awaddr_reg == igf_pkg::ADDR_OUT_DATA && wstrb_reg == 4'hF
        |=> relay_ctrl_n == $past(wdata_reg[N_OUT-1:0]))
        else $error("relay pins do not follow written value");

    a_out_readback: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == igf_pkg::ADDR_OUT_DATA
        |=> s_axi_rvalid && s_axi_rdata[N_OUT-1:0] == $past(relay_ctrl_n))
        else $error("output readback mismatch");

    a_filt_off_rst: assert property (@(posedge aclk)
        !aresetn |=> filt_en_reg == '0)
        else $error("filtering enabled after reset");

    a_bypass_path: assert property (@(posedge aclk) disable iff (!aresetn)
        in_level == $past((clean_reg & ~filt_en_reg) | (filt_q_reg & filt_en_reg)))
        else $error("line routed on wrong path");

    a_sample_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        sample_en |=> !sample_en [*8] ##1 !sample_en [*8] ##1 !sample_en [*3] ##1 sample_en)
        else $error("sample tick not every 100 ns");

    a_filt_moves_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        filt_q_reg != $past(filt_q_reg) |-> $past(filt_tick) && $past(steady_reg)
        == $past(steady_reg) && ($past(steady_reg) & (filt_q_reg ^ $past(filt_q_reg)))
        == (filt_q_reg ^ $past(filt_q_reg)))
        else $error("filtered level changed without two steady ticks");

    a_filt_level_src: assert property (@(posedge aclk) disable iff (!aresetn)
        filt_tick |=> ((filt_q_reg ^ $past(filt_q_reg)) & ($past(samp_reg)
        ^ $past(edge_lvl_reg))) == '0)
        else $error("filter accepted level differing from last tick");

    a_change_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_lvl ^ prev_sel_reg) != '0 |=> (change_reg & $past(sel_lvl ^ prev_sel_reg))
        == $past(sel_lvl ^ prev_sel_reg))
        else $error("change on selected path not flagged");

endmodule // igf_glitch_filter

`default_nettype wire

// ==== igf_host_model.sv ====
// host side of the register bus: axi4-lite master tasks
// assumes callers enter a task just after a rising edge of aclk
`default_nettype none

module igf_host_model (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end

    // handshakes are judged mid-cycle and take effect at the next rising edge,
    // which avoids racing the slave's own updates on that edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r,
                          input logic [3:0] s);
        logic ad;
        logic wd;
        logic ha;
        logic hw;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ha = !ad && s_axi_awready;
            hw = !wd && s_axi_wready;
            @(posedge aclk);
            if (ha) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (hw) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(negedge aclk);
            ha = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!ha);
        s_axi_bready <= 1'b0;
        @(posedge aclk); // never raise a strobe twice in one step
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic h;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            h = s_axi_arready;
            @(posedge aclk);
        end while (!h);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!h);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule // igf_host_model

`default_nettype wire

// ==== igf_pkg.sv ====
// constants shared by the isolated i/o glitch filter block
// assumes a 200 MHz aclk and a 32-bit axi4-lite register bus
`default_nettype none

package igf_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int SAMPLE_NS = 100;
    localparam int SAMPLE_CYC = SAMPLE_NS / CLK_PERIOD_NS;
    localparam int NS_PER_US = 1000;
    localparam int SAMPLES_PER_US = NS_PER_US / SAMPLE_NS;
    localparam int INTERVAL_MIN_US = 1000;
    localparam int INTERVAL_MAX_US = 100000;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_OUT_DATA = 8'h00;
    localparam logic [7:0] ADDR_IN_DATA = 8'h04;
    localparam logic [7:0] ADDR_FILT_EN = 8'h08;
    localparam logic [7:0] ADDR_FILT_INTERVAL = 8'h0C;
    localparam logic [7:0] ADDR_CHANGE_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RAW_IN = 8'h14;

    // ****************************************************************
    // widths and reset values
    // ****************************************************************
    localparam int INTERVAL_W = 17;
    localparam int HALF_W = 21;
    localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 17'h003E8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : igf_pkg

`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the glitch filter and relay latch
// assumes igf_pkg and igf_host_model are compiled first
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // clock, reset, wiring
    // ****************************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [23:0] in_pins = 24'h000000;
    logic [23:0] relay_ctrl_n, in_level;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #2.5 aclk = ~aclk;

    igf_glitch_filter i_igf_glitch_filter (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_pins(in_pins),
        .relay_ctrl_n(relay_ctrl_n), .in_level(in_level));

    igf_host_model i_igf_host_model (.aclk(aclk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ****************************************************************
    // compare and access helpers
    // ****************************************************************
    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // cut a hang short; whole run needs well under 10000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t value got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t resp got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                          input logic [3:0] s = 4'hF);
        logic [1:0] r;
        i_igf_host_model.axi_wr({24'h000000, a}, d, r, s);
        chk_resp(r, er);
    endtask

    // masked read so that flags of unrelated lines do not matter
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                          input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        i_igf_host_model.axi_rd({24'h000000, a}, d, r);
        chk_resp(r, er);
        chk_val(d & m, exp);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // pulse lines 0..2 to lvl for w+1 cycles; 0 and 1 filtered, 2 bypassed
    task automatic t_pulse(input logic lvl, input int w, input logic exp);
        logic [2:0] seen;
        seen = 3'h0;
        @(posedge aclk);
        in_pins[2:0] <= {3{lvl}};
        for (int i = 0; i < w + 500; i++) begin
            @(posedge aclk);
            if (i == w) in_pins[2:0] <= {3{!lvl}};
            @(negedge aclk);
            for (int b = 0; b < 3; b++) if (in_level[b] === lvl) seen[b] = 1'b1;
        end
        chk_val({29'h0, seen}, {29'h0, 1'b1, exp, exp});
    endtask

    // a step on lines 0 and 1 must land 80 to 240 cycles after it is driven
    task automatic t_step(input logic lvl);
        int n;
        n = 0;
        @(posedge aclk);
        in_pins[2:0] <= {3{lvl}};
        while (in_level[0] !== lvl && n < 400) begin
            @(negedge aclk);
            n++;
        end
        chk_val({31'h0, n >= 80 && n <= 240}, 32'h00000001);
        chk_val({31'h0, in_level[1]}, {31'h0, lvl});
        @(posedge aclk);
    endtask

    task automatic t_bypass();
        @(posedge aclk);
        in_pins <= 24'hA5005A;
        repeat (12) @(posedge aclk);
        chk_val({8'h00, in_level}, 32'h00A5005A);
        reg_rd(igf_pkg::ADDR_IN_DATA, 32'h00A5005A, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        in_pins <= 24'h000000;
        repeat (12) @(posedge aclk);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_val({8'h00, relay_ctrl_n}, 32'h00FFFFFF);
        reg_rd(igf_pkg::ADDR_OUT_DATA, 32'h00FFFFFF, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        reg_rd(igf_pkg::ADDR_FILT_EN, 32'h0, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        reg_rd(igf_pkg::ADDR_FILT_INTERVAL, 32'h000003E8, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        reg_wr(igf_pkg::ADDR_FILT_INTERVAL, 32'h000186A0, igf_pkg::RESP_OKAY);
        reg_rd(igf_pkg::ADDR_FILT_INTERVAL, 32'h000186A0, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        reg_wr(igf_pkg::ADDR_OUT_DATA, 32'h00005AC3, igf_pkg::RESP_OKAY);
        chk_val({8'h00, relay_ctrl_n}, 32'h00005AC3);
        reg_wr(8'h3C, 32'h0, igf_pkg::RESP_SLVERR);
        reg_rd(8'h3C, 32'h0, 32'hFFFFFFFF, igf_pkg::RESP_SLVERR);
        reg_rd(igf_pkg::ADDR_OUT_DATA, 32'h00005AC3, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        // only byte 1 is strobed, the other relays keep their state
        reg_wr(igf_pkg::ADDR_OUT_DATA, 32'h00123456, igf_pkg::RESP_OKAY, 4'h2);
        chk_val({8'h00, relay_ctrl_n}, 32'h000034C3);
        reg_rd(igf_pkg::ADDR_OUT_DATA, 32'h000034C3, 32'hFFFFFFFF, igf_pkg::RESP_OKAY);
        t_bypass();
        // below the legal range on purpose: 1 us makes each filter tick 100 cycles
        reg_wr(igf_pkg::ADDR_FILT_INTERVAL, 32'h00000001, igf_pkg::RESP_OKAY);
        reg_wr(igf_pkg::ADDR_FILT_EN, 32'h00000003, igf_pkg::RESP_OKAY);
        repeat (300) @(posedge aclk);
        reg_wr(igf_pkg::ADDR_CHANGE_STATUS, 32'h00FFFFFF, igf_pkg::RESP_OKAY);
        t_pulse(1'b1, 60, 1'b0);
        reg_rd(igf_pkg::ADDR_CHANGE_STATUS, 32'h0, 32'h00000003, igf_pkg::RESP_OKAY);
        t_pulse(1'b1, 240, 1'b1);
        reg_rd(igf_pkg::ADDR_CHANGE_STATUS, 32'h1, 32'h00000001, igf_pkg::RESP_OKAY);
        t_step(1'b1);
        t_pulse(1'b0, 60, 1'b0);
        t_pulse(1'b0, 240, 1'b1);
        t_step(1'b0);
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
